// file: itt_pkg.sv
// shared constants, types and helpers of the interval / time-base timer
package itt_pkg;

  // register indices on the plain register port
  localparam logic [2:0] ADDR_MODE    = 3'h0;
  localparam logic [2:0] ADDR_COUNT   = 3'h1;
  localparam logic [2:0] ADDR_STATUS  = 3'h2;
  localparam logic [2:0] ADDR_CLEAR   = 3'h3;
  localparam logic [2:0] ADDR_ENABLE  = 3'h4;
  localparam logic [2:0] ADDR_PORTMOD = 3'h5;

  // mode register layout
  localparam logic [7:0] MODE_RESET    = 8'h10;
  localparam int         MODE_RSV_BIT  = 4;
  localparam int         MODE_TB_BIT   = 3;
  localparam int         MODE_OUT_SRC  = 7;
  localparam logic [1:0] MODE_CLR_CODE = 2'h3;
  localparam logic [1:0] MODE_TB_CODE  = 2'h2;

  // irq status / clear / enable layout, port mode layout
  localparam int         IRQ_OVF_BIT   = 0;
  localparam int         PORT_CLKO_BIT = 0;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] COUNT_MAX     = 8'hff;

  // prescaler sizes and taps
  localparam int         PSS_BITS      = 13;
  localparam int         PSW_BITS      = 7;
  localparam logic [2:0] OUT_TAP_DIV32 = 3'h4;

  // sub-clock rate and time-base periods; taps are log2 of sub clocks per count
  localparam int SUB_CLK_HZ     = 32768;
  localparam int TB_PERIOD_1S_US    = 1000000;
  localparam int TB_PERIOD_31MS_US  = 31250;
  localparam int TB_COUNTS_PER_OVF  = 256;
  localparam int TB_TAP_1S    = $clog2(SUB_CLK_HZ / TB_COUNTS_PER_OVF);
  localparam int TB_TAP_31MS  = $clog2((SUB_CLK_HZ / 32) / TB_COUNTS_PER_OVF);

  typedef enum logic [2:0] {
    ITT_ACTIVE,
    ITT_SLEEP,
    ITT_WATCH,
    ITT_SUBACTIVE,
    ITT_SUBSLEEP,
    ITT_STANDBY
  } itt_pwr_e;

  // true once every 2**k counts, when all bits below k are ones
  function automatic logic tap_hit(input logic [15:0] cnt, input logic [3:0] k);
    logic [15:0] mask;
    mask = (16'h0001 << k) - 16'h0001;
    return (cnt & mask) == mask;
  endfunction : tap_hit

  function automatic logic [3:0] sys_tap(input logic [2:0] sel);
    logic [3:0] k;
    case (sel)
      3'h0:    k = 4'hd;
      3'h1:    k = 4'hc;
      3'h2:    k = 4'hb;
      3'h3:    k = 4'h9;
      3'h4:    k = 4'h8;
      3'h5:    k = 4'h7;
      3'h6:    k = 4'h5;
      default: k = 4'h3;
    endcase
    return k;
  endfunction : sys_tap

  function automatic logic [3:0] sub_tap(input logic [1:0] sel);
    logic [3:0] k;
    case (sel)
      2'h0:    k = 4'(TB_TAP_1S);
      2'h1:    k = 4'(TB_TAP_1S - 1);
      2'h2:    k = 4'(TB_TAP_1S - 2);
      default: k = 4'(TB_TAP_31MS);
    endcase
    return k;
  endfunction : sub_tap

endpackage : itt_pkg

// file: itt_sync.sv
// two-flop synchroniser with rising-edge pulse
`timescale 1ns/100ps
`default_nettype none
module itt_sync (
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  input  wire logic async_i,
  output var  logic rise_o
);
  logic meta;
  logic stable;
  logic prev;

  // meta feeds only stable; edge detect looks at stable and prev
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      prev   <= 1'b0;
    end else begin
      meta   <= async_i;
      stable <= meta;
      prev   <= stable;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rise_o <= 1'b0;
    end else begin
      rise_o <= stable & ~prev;
    end
  end
endmodule : itt_sync
`default_nettype wire

// file: itt_timer.sv
// interval timer / clock time base with clock output
//
// Operation
// - out select 000-011 gives sys clock /32../4, 100-111 sub clock /32../4
// - sys output only in active/sleep; sub output also in subactive/subsleep
// - mode bit 4 reads as 1, writes to it ignored
// - bit3=0: interval, bits 2:0 pick sys tap /8192,/4096,/2048,/512,/256,/128,/32,/8
// - bits 3:2=10: time base, bits 1:0 pick 1, 0.5, 0.25, 0.03125 s
// - writing bits 3:2 as 11 clears counter and sub-clock prescaler
// - mode register resets to 0x10
// - counter read-only, counts selected clock, reads zero in subactive
// - counter overflow sets the overflow request flag
// - counter resets to zero
// - count after 0xff overflows and wraps to zero, every 256 inputs
// - flag set and enable set raise the interrupt
// - reset clears counter and bit3 so interval counting starts at once
// - clock output driven only while port mode enable bit is 1
// - interval halts outside active/sleep; time base halts only in standby
// - sub-clock synchronised into system clock before counting
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module itt_timer #(
  parameter int PSS_W = itt_pkg::PSS_BITS,
  parameter int PSW_W = itt_pkg::PSW_BITS
) (
  input  wire logic             ref_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             sub_clk_i,
  input  wire itt_pkg::itt_pwr_e pwr_mode_i,
  input  wire logic [2:0]       addr_i,
  input  wire logic [7:0]       wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output var  logic [7:0]       rdata_o,
  output var  logic             irq_o,
  output var  logic             clk_out_o
);

  if (PSS_W < itt_pkg::PSS_BITS || PSS_W > 16) begin : g_pss_chk
    $error("PSS_W must be 13 to 16");
  end
  if (PSW_W < itt_pkg::PSW_BITS || PSW_W > 16) begin : g_psw_chk
    $error("PSW_W must be 7 to 16");
  end

  logic [7:0]       mode_reg;
  logic [7:0]       count;
  logic [7:0]       irq_status;
  logic [7:0]       irq_enable;
  logic [7:0]       port_mode;
  logic [PSS_W-1:0] system_prescaler;
  logic [PSW_W-1:0] subclock_prescaler;
  logic             sub_rise;
  logic             sys_run;
  logic             sub_run;
  logic             is_tb;
  logic             is_clr;
  logic             sys_tick;
  logic             sub_tick;
  logic             cnt_tick;
  logic             ovf;
  logic             wr_mode;
  logic             clr_wr;
  logic             reg_wr_ok;
  logic             next_clk_out;
  logic [7:0]       next_rdata;

  itt_sync u_sub_sync (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   (sub_clk_i),
    .rise_o    (sub_rise)
  );

  // power-mode gating
  assign sys_run = (pwr_mode_i == itt_pkg::ITT_ACTIVE) || (pwr_mode_i == itt_pkg::ITT_SLEEP);
  assign sub_run = pwr_mode_i != itt_pkg::ITT_STANDBY;
  // the cpu only writes while it runs; elsewhere the mode register is retained
  assign reg_wr_ok = (pwr_mode_i == itt_pkg::ITT_ACTIVE) || (pwr_mode_i == itt_pkg::ITT_SUBACTIVE);

  assign is_tb  = mode_reg[3:2] == itt_pkg::MODE_TB_CODE;
  assign is_clr = mode_reg[3:2] == itt_pkg::MODE_CLR_CODE;
  assign wr_mode = wr_i && reg_wr_ok && (addr_i == itt_pkg::ADDR_MODE);
  assign clr_wr  = wr_mode && (wdata_i[3:2] == itt_pkg::MODE_CLR_CODE);

  // system prescaler, free running
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      system_prescaler <= '0;
    end else begin
      system_prescaler <= system_prescaler + PSS_W'(1);
    end
  end

  // sub-clock prescaler, counts synchronised sub-clock edges
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      subclock_prescaler <= '0;
    end else if (clr_wr) begin
      subclock_prescaler <= '0;
    end else if (sub_rise && sub_run) begin
      subclock_prescaler <= subclock_prescaler + PSW_W'(1);
    end
  end

  // tap period ends become one-cycle count enables
  assign sys_tick = !mode_reg[itt_pkg::MODE_TB_BIT] && sys_run
                    && itt_pkg::tap_hit(16'(system_prescaler), itt_pkg::sys_tap(mode_reg[2:0]));
  assign sub_tick = is_tb && sub_run && sub_rise
                    && itt_pkg::tap_hit(16'(subclock_prescaler), itt_pkg::sub_tap(mode_reg[1:0]));
  assign cnt_tick = sys_tick || sub_tick;
  assign ovf      = cnt_tick && (count == itt_pkg::COUNT_MAX);

  // mode register; bit 4 fixed so the reserved bit always reads 1
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_reg <= itt_pkg::MODE_RESET;
    end else if (wr_mode) begin
      mode_reg <= wdata_i | itt_pkg::MODE_RESET;
    end
  end

  // up counter
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= itt_pkg::COUNT_RESET;
    end else if (clr_wr || is_clr) begin
      count <= itt_pkg::COUNT_RESET;
    end else if (cnt_tick) begin
      count <= count + 8'h01;
    end
  end

  // sticky status: hardware set wins over a same-cycle software clear
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_status <= 8'h00;
    end else begin
      if (wr_i && reg_wr_ok && addr_i == itt_pkg::ADDR_CLEAR) begin
        irq_status <= irq_status & ~wdata_i;
      end
      if (ovf) begin
        irq_status[itt_pkg::IRQ_OVF_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_enable <= 8'h00;
    end else if (wr_i && reg_wr_ok && addr_i == itt_pkg::ADDR_ENABLE) begin
      irq_enable <= wdata_i & 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port_mode <= 8'h00;
    end else if (wr_i && reg_wr_ok && addr_i == itt_pkg::ADDR_PORTMOD) begin
      port_mode <= wdata_i & 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_enable);
    end
  end

  // clock output: prescaler bit (4 - sel) is a square wave of /32 down to /4
  always_comb begin
    next_clk_out = 1'b0;
    if (port_mode[itt_pkg::PORT_CLKO_BIT]) begin
      if (!mode_reg[itt_pkg::MODE_OUT_SRC]) begin
        if (sys_run) begin
          next_clk_out = system_prescaler[itt_pkg::OUT_TAP_DIV32 - {1'b0, mode_reg[6:5]}];
        end
      end else if (sub_run && pwr_mode_i != itt_pkg::ITT_WATCH) begin
        next_clk_out = subclock_prescaler[itt_pkg::OUT_TAP_DIV32 - {1'b0, mode_reg[6:5]}];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_out_o <= 1'b0;
    end else begin
      clk_out_o <= next_clk_out;
    end
  end

  // read mux; unmapped and write-only addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    case (addr_i)
      itt_pkg::ADDR_MODE:    next_rdata = mode_reg | itt_pkg::MODE_RESET;
      itt_pkg::ADDR_COUNT:   next_rdata = (pwr_mode_i == itt_pkg::ITT_SUBACTIVE) ? 8'h00 : count;
      itt_pkg::ADDR_STATUS:  next_rdata = irq_status;
      itt_pkg::ADDR_ENABLE:  next_rdata = irq_enable;
      itt_pkg::ADDR_PORTMOD: next_rdata = port_mode;
      default:               next_rdata = 8'h00;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? next_rdata : 8'h00;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_rsv_bit;
    rd_i && addr_i == itt_pkg::ADDR_MODE |=> rdata_o[4];
  endproperty
  a_rsv_bit: assert property (p_rsv_bit) else $error("reserved mode bit read as 0");

  property p_mode_hold;
    !wr_mode |=> $stable(mode_reg) && mode_reg[itt_pkg::MODE_RSV_BIT];
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode register changed without a write");

  property p_clear;
    clr_wr |=> count == 8'h00 && subclock_prescaler == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear code did not clear counter");

  property p_wrap;
    ovf && !clr_wr && !is_clr |=> count == 8'h00 && irq_status[itt_pkg::IRQ_OVF_BIT];
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow did not wrap and flag");

  property p_irq;
    irq_status[0] && irq_enable[0] |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled flag raised no interrupt");

  property p_clk_gate;
    !port_mode[itt_pkg::PORT_CLKO_BIT] |=> !clk_out_o;
  endproperty
  a_clk_gate: assert property (p_clk_gate) else $error("clock out while disabled");

  property p_sys_out_off;
    !mode_reg[7] && pwr_mode_i == itt_pkg::ITT_SUBACTIVE |=> !clk_out_o;
  endproperty
  a_sys_out_off: assert property (p_sys_out_off) else $error("system clock out in subactive");

  property p_halt;
    !mode_reg[3] && !sys_run && !wr_mode |=> $stable(count);
  endproperty
  a_halt: assert property (p_halt) else $error("interval counter ran while halted");

  property p_step;
    cnt_tick && !ovf && !clr_wr && !is_clr |=> count == $past(count) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("counter did not step once");

  property p_sub_read;
    rd_i && addr_i == itt_pkg::ADDR_COUNT && pwr_mode_i == itt_pkg::ITT_SUBACTIVE |=> rdata_o == 8'h00;
  endproperty
  a_sub_read: assert property (p_sub_read) else $error("count readable in subactive");

  property p_int_rate;
    sys_tick |=> !sys_tick [*2];
  endproperty
  a_int_rate: assert property (p_int_rate) else $error("interval ticks too close");

  property p_mode_wr;
    wr_mode |=> mode_reg == ($past(wdata_i) | itt_pkg::MODE_RESET);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write did not land");

  property p_clr_hold;
    is_clr |=> count == itt_pkg::COUNT_RESET;
  endproperty
  a_clr_hold: assert property (p_clr_hold) else $error("counter not held clear");

  property p_standby;
    pwr_mode_i == itt_pkg::ITT_STANDBY |=> $stable(count);
  endproperty
  a_standby: assert property (p_standby) else $error("counter ran in standby");

  property p_irq_off;
    !(irq_status[itt_pkg::IRQ_OVF_BIT] && irq_enable[itt_pkg::IRQ_OVF_BIT]) |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt without enabled flag");

  property p_status_hold;
    irq_status[itt_pkg::IRQ_OVF_BIT] && !(wr_i && addr_i == itt_pkg::ADDR_CLEAR && wdata_i[itt_pkg::IRQ_OVF_BIT])
    |=> irq_status[itt_pkg::IRQ_OVF_BIT];
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("overflow flag lost without a clear");

  property p_status_set;
    !irq_status[itt_pkg::IRQ_OVF_BIT] && !ovf |=> !irq_status[itt_pkg::IRQ_OVF_BIT];
  endproperty
  a_status_set: assert property (p_status_set) else $error("overflow flag set without overflow");

  property p_count_read;
    rd_i && addr_i == itt_pkg::ADDR_COUNT && pwr_mode_i != itt_pkg::ITT_SUBACTIVE |=> rdata_o == $past(count);
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read returned a wrong value");

  property p_sub_out_off;
    mode_reg[itt_pkg::MODE_OUT_SRC] && (pwr_mode_i == itt_pkg::ITT_WATCH || pwr_mode_i == itt_pkg::ITT_STANDBY)
    |=> !clk_out_o;
  endproperty
  a_sub_out_off: assert property (p_sub_out_off) else $error("sub clock out in watch or standby");

  property p_tb_edge;
    is_tb && !sub_rise && !wr_mode |=> $stable(count);
  endproperty
  a_tb_edge: assert property (p_tb_edge) else $error("time base counted without a sub edge");

  property p_psw_step;
    sub_rise && sub_run && !clr_wr |=> subclock_prescaler == $past(subclock_prescaler) + PSW_W'(1);
  endproperty
  a_psw_step: assert property (p_psw_step) else $error("sub prescaler missed an edge");

  property p_port_wr;
    wr_i && reg_wr_ok && addr_i == itt_pkg::ADDR_PORTMOD
    |=> port_mode[itt_pkg::PORT_CLKO_BIT] == $past(wdata_i[itt_pkg::PORT_CLKO_BIT]);
  endproperty
  a_port_wr: assert property (p_port_wr) else $error("clock output enable write lost");

  property p_en_wr;
    wr_i && reg_wr_ok && addr_i == itt_pkg::ADDR_ENABLE
    |=> irq_enable[itt_pkg::IRQ_OVF_BIT] == $past(wdata_i[itt_pkg::IRQ_OVF_BIT]);
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("interrupt enable write lost");

  c_overflow: cover property (ovf);
  c_clear:    cover property (clr_wr);
  c_irq:      cover property ($rose(irq_o));
  c_tb_tick:  cover property (sub_tick);
  c_sub_out:  cover property (pwr_mode_i == itt_pkg::ITT_SUBSLEEP && clk_out_o);

endmodule : itt_timer
`default_nettype wire

// file: test_itt_timer.sv
// self-checking bench of the interval / time-base timer
`timescale 1ns/100ps
`default_nettype none
module test_itt_timer;
  logic              ref_clk_i = 1'b0;
  logic              arst_n_i;
  logic              sub_clk_i;
  itt_pkg::itt_pwr_e pwr_mode_i;
  logic [2:0]        addr_i;
  logic [7:0]        wdata_i;
  logic              wr_i;
  logic              rd_i;
  logic [7:0]        rdata_o;
  logic              irq_o;
  logic              clk_out_o;
  logic [7:0]        v;
  int                fails = 0;
  int                cmp_count = 0;
  int                n;
  int                divs[8] = '{8192, 4096, 2048, 512, 256, 128, 32, 8};
  int                tbc[4] = '{1024, 512, 256, 32};

  always #25 ref_clk_i = ~ref_clk_i;
  // sub-clock runs far faster than a watch crystal so the time base finishes quickly
  initial begin
    sub_clk_i = 1'b0;
    #13;
    forever #200 sub_clk_i = ~sub_clk_i;
  end

  itt_timer uut (
    .ref_clk_i  (ref_clk_i),
    .arst_n_i   (arst_n_i),
    .sub_clk_i  (sub_clk_i),
    .pwr_mode_i (pwr_mode_i),
    .addr_i     (addr_i),
    .wdata_i    (wdata_i),
    .wr_i       (wr_i),
    .rd_i       (rd_i),
    .rdata_o    (rdata_o),
    .irq_o      (irq_o),
    .clk_out_o  (clk_out_o)
  );

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic pwr(input itt_pkg::itt_pwr_e m);
    @(posedge ref_clk_i);
    pwr_mode_i <= m;
  endtask : pwr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  // count advance across exactly gap cycles between the two sampling edges
  task automatic delta(input int gap, output logic [7:0] d);
    logic [7:0] c0;
    logic [7:0] c1;
    rd(itt_pkg::ADDR_COUNT, c0);
    repeat (gap - 2) @(posedge ref_clk_i);
    rd(itt_pkg::ADDR_COUNT, c1);
    d = c1 - c0;
  endtask : delta

  task automatic per(output int p);
    int   r;
    int   k;
    logic q;
    p = 0;
    r = 0;
    k = 0;
    q = clk_out_o;
    // first rise may be the select switch itself, so time the second to the third
    while (r < 3 && k < 1000) begin
      @(posedge ref_clk_i);
      #1;
      if (r == 2) p++;
      if (clk_out_o === 1'b1 && q === 1'b0) r++;
      q = clk_out_o;
      k++;
    end
    if (k >= 1000) fails++;
  endtask : per

  task automatic quiet;
    logic seen;
    seen = 1'b0;
    repeat (300) begin
      @(posedge ref_clk_i);
      #1;
      if (clk_out_o !== 1'b0) seen = 1'b1;
    end
    chk(16'(seen), 16'h0);
  endtask : quiet

  task automatic wait_irq(output int k);
    k = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      k++;
    end while (irq_o !== 1'b1 && k < 3000);
    if (k >= 3000) fails++;
  endtask : wait_irq

  initial begin
    #(90000 * 50);
    fails++;
    stop_test();
  end

  initial begin
    arst_n_i   = 1'b0;
    pwr_mode_i = itt_pkg::ITT_ACTIVE;
    addr_i     = 3'h0;
    wdata_i    = 8'h00;
    wr_i       = 1'b0;
    rd_i       = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    rd(itt_pkg::ADDR_MODE, v); chk(16'(v), 16'h0010);
    rd(itt_pkg::ADDR_COUNT, v); chk(16'(v), 16'h0000);
    delta(2 * divs[0], v); chk(16'(v), 16'h0002);
    wr(itt_pkg::ADDR_MODE, 8'h00);
    rd(itt_pkg::ADDR_MODE, v); chk(16'(v), 16'h0010);
    for (int s = 1; s < 8; s++) begin
      wr(itt_pkg::ADDR_MODE, 8'(s));
      delta(2 * divs[s], v); chk(16'(v), 16'h0002);
    end
    wr(itt_pkg::ADDR_MODE, 8'h0c);
    wr(itt_pkg::ADDR_COUNT, 8'h55);
    rd(itt_pkg::ADDR_COUNT, v); chk(16'(v), 16'h0000);
    rd(itt_pkg::ADDR_MODE, v); chk(16'(v), 16'h001c);
    for (int s = 0; s < 4; s++) begin
      wr(itt_pkg::ADDR_MODE, 8'h0c);
      wr(itt_pkg::ADDR_MODE, 8'h08 | 8'(s));
      delta(2 * tbc[s], v); chk(16'(v), 16'h0002);
    end
    // time base keeps running in watch, halts in standby
    pwr(itt_pkg::ITT_WATCH);
    delta(256, v); chk(16'(v), 16'h0008);
    pwr(itt_pkg::ITT_STANDBY);
    delta(256, v); chk(16'(v), 16'h0000);
    pwr(itt_pkg::ITT_SUBACTIVE);
    rd(itt_pkg::ADDR_COUNT, v); chk(16'(v), 16'h0000);
    pwr(itt_pkg::ITT_ACTIVE);
    wr(itt_pkg::ADDR_MODE, 8'h07);
    pwr(itt_pkg::ITT_SLEEP);
    delta(128, v); chk(16'(v), 16'h0010);
    wr(itt_pkg::ADDR_MODE, 8'h00);
    rd(itt_pkg::ADDR_MODE, v); chk(16'(v), 16'h0017);
    pwr(itt_pkg::ITT_WATCH);
    delta(128, v); chk(16'(v), 16'h0000);
    pwr(itt_pkg::ITT_ACTIVE);
    wr(itt_pkg::ADDR_PORTMOD, 8'h00);
    quiet();
    wr(itt_pkg::ADDR_PORTMOD, 8'h01);
    for (int s = 0; s < 8; s++) begin
      wr(itt_pkg::ADDR_MODE, {3'(s), 5'h07});
      per(n); chk(16'(n), 16'((s < 4 ? 32 : 256) >> (s % 4)));
    end
    pwr(itt_pkg::ITT_SUBACTIVE);
    per(n); chk(16'(n), 16'h0020);
    pwr(itt_pkg::ITT_SUBSLEEP);
    per(n); chk(16'(n), 16'h0020);
    pwr(itt_pkg::ITT_WATCH);
    quiet();
    pwr(itt_pkg::ITT_ACTIVE);
    wr(itt_pkg::ADDR_MODE, 8'h67);
    pwr(itt_pkg::ITT_SUBACTIVE);
    quiet();
    pwr(itt_pkg::ITT_ACTIVE);
    wr(itt_pkg::ADDR_MODE, 8'h0c);
    wr(itt_pkg::ADDR_CLEAR, 8'h01);
    wr(itt_pkg::ADDR_ENABLE, 8'h01);
    wr(itt_pkg::ADDR_MODE, 8'h07);
    wait_irq(n);
    wr(itt_pkg::ADDR_CLEAR, 8'h01);
    wait_irq(n); chk(16'(n), 16'd2046);
    rd(itt_pkg::ADDR_STATUS, v); chk(16'(v), 16'h0001);
    wr(itt_pkg::ADDR_ENABLE, 8'h00);
    @(posedge ref_clk_i);
    #1;
    chk(16'(irq_o), 16'h0000);
    wr(itt_pkg::ADDR_ENABLE, 8'h01);
    @(posedge ref_clk_i);
    #1;
    chk(16'(irq_o), 16'h0001);
    wr(itt_pkg::ADDR_CLEAR, 8'h01);
    @(posedge ref_clk_i);
    #1;
    chk(16'(irq_o), 16'h0000);
    rd(itt_pkg::ADDR_STATUS, v); chk(16'(v), 16'h0000);
    stop_test();
  end
endmodule : test_itt_timer
`default_nettype wire
